// ### logic/isbie_expander.sv
// Sixteen-bit serial I/O expander: link target on its own clock, registers and pins on the core clock.
// Assumes external pull-ups on the data line and the interrupt line; the link clock stands still between frames.
//
// What this block does
// - Two 8-bit ports, each with direction, input, output and inversion registers.
// - After reset every pin is an input and no output driver is on.
// - A written direction bit decides whether the matching pin drives.
// - Input register captures pin levels; output pins follow output-register bits.
// - A set inversion bit reports the inverted pin level in the input register.
// - Every register, configuration included, reads back over the serial link.
// - Reset restores all register defaults and returns the link engine to idle.
// - Interrupt asserts while any input pin differs from its captured state.
// - Interrupt output is open-drain, pulling low only when asserted.
// - Three strap pins give the low three address bits; eight devices share.
// - Link works up to fast mode; the master must not clock faster.
// - Output pins hold the last written value until rewritten or reset.
// - Answer addresses 0x20 to 0x27, last bit one for read.
// - First written byte after address is the command choosing one of eight registers.
// - The chosen register stays selected for reads until a new command.
// - Input registers show pins in any direction; writes to them are ignored.
module isbie_expander (
  // Core clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Serial link
  input wire logic link_scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Address straps
  input wire logic addr_select_bit0,
  input wire logic addr_select_bit1,
  input wire logic addr_select_bit2,
  // Port 0 pins
  input wire logic [isbie_pkg::PORT_W-1:0] port0_pin,
  output logic [isbie_pkg::PORT_W-1:0] port0_pin_out,
  output logic [isbie_pkg::PORT_W-1:0] port0_pin_oe,
  // Port 1 pins
  input wire logic [isbie_pkg::PORT_W-1:0] port1_pin,
  output logic [isbie_pkg::PORT_W-1:0] port1_pin_out,
  output logic [isbie_pkg::PORT_W-1:0] port1_pin_oe,
  // Interrupt line
  output logic int_out,
  output logic int_oe
);
  import isbie_pkg::*;

  // Reset release
  logic rst_meta_b;
  logic rst_sync_b;

  // Link domain state
  isbie_link_e link_state;
  logic [3:0] bit_cnt;
  logic [PORT_W-1:0] rx_shift;
  logic [PORT_W-1:0] tx_shift;
  logic [2:0] reg_ptr;
  logic [PORT_W-1:0] wr_data;
  logic wr_tog;
  logic rd_tog;
  logic start_tog;
  logic start_ack;
  logic start_new;
  logic addr_match;
  logic [2:0] addr_strap;

  // Core domain state
  logic [NUM_PORTS-1:0][PORT_W-1:0] out_reg;
  logic [NUM_PORTS-1:0][PORT_W-1:0] pol_reg;
  logic [NUM_PORTS-1:0][PORT_W-1:0] cfg_reg;
  logic [NUM_PORTS-1:0][PORT_W-1:0] snap_reg;
  logic [NUM_PORTS-1:0][PORT_W-1:0] pin_now;
  logic [NUM_PORTS-1:0][PORT_W-1:0] in_val;
  logic [PORT_W-1:0] rd_byte;
  logic [PORT_W-1:0] next_rd_byte;
  logic snap_loaded;
  logic [SYNC_STAGES-1:0] snap_fill;
  logic wr_tog_d;
  logic rd_tog_d;
  logic wr_evt;
  logic rd_evt;
  logic [1:0] ptr_kind;
  logic ptr_port;

  // Crossings
  isbie_sync_if #(.W(PIN_W)) pin_if ();
  isbie_sync_if #(.W(2)) tog_if ();
  isbie_sync_if #(.W(3)) strap_if ();

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_b <= 1'h0;
      rst_sync_b <= 1'h0;
    end else begin
      rst_meta_b <= 1'h1;
      rst_sync_b <= rst_meta_b;
    end
  end

  assign pin_if.async_d = {port1_pin, port0_pin};
  assign tog_if.async_d = {rd_tog, wr_tog};
  assign strap_if.async_d = {addr_select_bit2, addr_select_bit1, addr_select_bit0};

  isbie_sync #(.W(PIN_W), .STAGES(SYNC_STAGES)) u_pin_sync (
    .clock(clock),
    .rst_b(rst_sync_b),
    .bus(pin_if.sync)
  );

  isbie_sync #(.W(2), .STAGES(SYNC_STAGES)) u_tog_sync (
    .clock(clock),
    .rst_b(rst_sync_b),
    .bus(tog_if.sync)
  );

  // Straps are static during a frame, so sampling on the link clock is enough
  isbie_sync #(.W(3), .STAGES(SYNC_STAGES)) u_strap_sync (
    .clock(link_scl),
    .rst_b(rst_sync_b),
    .bus(strap_if.sync)
  );

  assign addr_strap = strap_if.sync_q;
  assign pin_now = pin_if.sync_q;

  // Start condition: falling data while the link clock is high
  always_ff @(negedge sda_in or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      start_tog <= 1'h0;
    end else if (link_scl) begin
      start_tog <= ~start_tog;
    end
  end

  assign start_new = start_tog ^ start_ack;

  // fixed upper nibble, general call never matches
  assign addr_match = (rx_shift[PORT_W-1:1] == {DEV_ADDR_HI, addr_strap});

  // Start acknowledge follows the toggle on every rising link edge
  always_ff @(posedge link_scl or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      start_ack <= 1'h0;
    end else begin
      start_ack <= start_tog;
    end
  end

  // Receive shifter samples data on the rising edge
  always_ff @(posedge link_scl or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      rx_shift <= '0;
    end else if (start_new || bit_cnt != BIT_ACK) begin
      rx_shift <= {rx_shift[PORT_W-2:0], sda_in};
    end
  end

  // link engine sequence, idle after reset
  always_ff @(posedge link_scl or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      link_state <= LINK_IDLE;
      bit_cnt <= BIT_ZERO;
    end else if (start_new) begin
      link_state <= LINK_ADDR;
      bit_cnt <= BIT_FIRST;
    end else if (bit_cnt != BIT_ACK) begin
      if (link_state != LINK_IDLE) begin
        bit_cnt <= bit_cnt + BIT_STEP;
      end
    end else begin
      bit_cnt <= BIT_ZERO;
      case (link_state)
        LINK_ADDR: begin
          if (!addr_match) begin
            link_state <= LINK_IDLE;
          end else if (rx_shift[RW_BIT] == RW_READ) begin
            link_state <= LINK_RDATA;
          end else begin
            link_state <= LINK_CMD;
          end
        end
        LINK_CMD: begin
          link_state <= LINK_WDATA;
        end
        LINK_WDATA: begin
          link_state <= LINK_WDATA;
        end
        LINK_RDATA: begin
          // A not-acknowledge from the master ends the read
          if (sda_in) begin
            link_state <= LINK_IDLE;
          end
        end
        default: begin
          link_state <= LINK_IDLE;
        end
      endcase
    end
  end

  // pointer stays until the next command byte
  always_ff @(posedge link_scl or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      reg_ptr <= PTR_RESET;
    end else if (!start_new && bit_cnt == BIT_ACK && link_state == LINK_CMD) begin
      reg_ptr <= rx_shift[2:0];
    end
  end

  // Write byte handed to the core with a toggle; data is set on the same edge
  always_ff @(posedge link_scl or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      wr_data <= '0;
      wr_tog <= 1'h0;
    end else if (!start_new && bit_cnt == BIT_ACK && link_state == LINK_WDATA) begin
      wr_data <= rx_shift;
      wr_tog <= ~wr_tog;
    end
  end

  // the read request goes out half a link period before its data is needed
  // Fast mode leaves at least SCL_MIN_HALF_CYC core cycles for the crossing
  always_ff @(posedge link_scl or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      rd_tog <= 1'h0;
    end else if (!start_new && bit_cnt == BIT_ACK) begin
      if (link_state == LINK_ADDR && addr_match && rx_shift[RW_BIT] == RW_READ) begin
        rd_tog <= ~rd_tog;
      end else if (link_state == LINK_RDATA && !sda_in) begin
        rd_tog <= ~rd_tog;
      end
    end
  end

  // Transmit shifter on the falling edge; first bit comes from the core byte
  always_ff @(negedge link_scl or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      tx_shift <= '0;
    end else if (link_state == LINK_RDATA && bit_cnt == BIT_ZERO) begin
      tx_shift <= {rd_byte[PORT_W-2:0], 1'h0};
    end else begin
      tx_shift <= {tx_shift[PORT_W-2:0], 1'h0};
    end
  end

  // read data and acknowledges drive the data line low
  always_ff @(negedge link_scl or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      sda_oe <= 1'h0;
    end else if (start_new) begin
      sda_oe <= 1'h0;
    end else if (bit_cnt == BIT_ACK) begin
      case (link_state)
        LINK_ADDR: sda_oe <= addr_match;
        LINK_CMD: sda_oe <= 1'h1;
        LINK_WDATA: sda_oe <= 1'h1;
        default: sda_oe <= 1'h0;
      endcase
    end else if (link_state == LINK_RDATA) begin
      if (bit_cnt == BIT_ZERO) begin
        sda_oe <= ~rd_byte[PORT_W-1];
      end else begin
        sda_oe <= ~tx_shift[PORT_W-1];
      end
    end else begin
      sda_oe <= 1'h0;
    end
  end

  // Open-drain levels are constant low; only the enables move
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      sda_out <= 1'h0;
      int_out <= 1'h0;
    end else begin
      sda_out <= 1'h0;
      int_out <= 1'h0;
    end
  end

  // Events from the link
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      wr_tog_d <= 1'h0;
      rd_tog_d <= 1'h0;
    end else begin
      wr_tog_d <= tog_if.sync_q[0];
      rd_tog_d <= tog_if.sync_q[1];
    end
  end

  assign wr_evt = tog_if.sync_q[0] ^ wr_tog_d;
  assign rd_evt = tog_if.sync_q[1] ^ rd_tog_d;
  assign ptr_kind = reg_ptr[2:1];
  assign ptr_port = reg_ptr[PTR_PORT_BIT];

  // two ports of output, inversion and direction registers
  // written direction lands in the direction register
  // outputs latch until rewritten or reset
  // writes to the input registers are dropped
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      out_reg <= {NUM_PORTS{OUT_RESET}};
      pol_reg <= {NUM_PORTS{POL_RESET}};
      cfg_reg <= {NUM_PORTS{CFG_RESET}};
    end else if (wr_evt) begin
      case (ptr_kind)
        KIND_OUT: out_reg[ptr_port] <= wr_data;
        KIND_POL: pol_reg[ptr_port] <= wr_data;
        KIND_CFG: cfg_reg[ptr_port] <= wr_data;
        default: out_reg <= out_reg;
      endcase
    end
  end

  // input register follows the pin in either direction
  // inversion bit flips the reported level
  assign in_val[0] = pin_now[0] ^ pol_reg[0];
  assign in_val[1] = pin_now[1] ^ pol_reg[1];

  // every register can be read back
  always_comb begin
    case (reg_ptr)
      REG_IN0: next_rd_byte = in_val[0];
      REG_IN1: next_rd_byte = in_val[1];
      REG_OUT0: next_rd_byte = out_reg[0];
      REG_OUT1: next_rd_byte = out_reg[1];
      REG_POL0: next_rd_byte = pol_reg[0];
      REG_POL1: next_rd_byte = pol_reg[1];
      REG_CFG0: next_rd_byte = cfg_reg[0];
      REG_CFG1: next_rd_byte = cfg_reg[1];
      default: next_rd_byte = '0;
    endcase
  end

  // Held steady while the link shifts it out
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      rd_byte <= '0;
    end else if (rd_evt) begin
      rd_byte <= next_rd_byte;
    end
  end

  // captured pin state, taken once the pin synchroniser has refilled
  // reading an input register recaptures that port
  // Capturing earlier would snapshot the flushed zeros and raise a false interrupt
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      snap_reg <= '0;
      snap_loaded <= 1'h0;
      snap_fill <= '0;
    end else begin
      snap_fill <= {snap_fill[SYNC_STAGES-2:0], 1'h1};
      if (!snap_loaded && snap_fill[SYNC_STAGES-1]) begin
        snap_reg <= pin_now;
        snap_loaded <= 1'h1;
      end else if (snap_loaded && rd_evt && ptr_kind == KIND_IN) begin
        snap_reg[ptr_port] <= pin_now[ptr_port];
      end
    end
  end

  // any input-configured pin away from its captured state
  // asserted means the line is pulled low
  // clears by itself once the inputs return
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      int_oe <= 1'h0;
    end else begin
      int_oe <= snap_loaded && (|((pin_now ^ snap_reg) & cfg_reg));
    end
  end

  // direction reset value keeps all drivers off
  // a clear direction bit turns the driver on
  // pins driven from the output register
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      port0_pin_out <= OUT_RESET;
      port1_pin_out <= OUT_RESET;
      port0_pin_oe <= ~CFG_RESET;
      port1_pin_oe <= ~CFG_RESET;
    end else begin
      port0_pin_out <= out_reg[0];
      port1_pin_out <= out_reg[1];
      port0_pin_oe <= ~cfg_reg[0];
      port1_pin_oe <= ~cfg_reg[1];
    end
  end

endmodule : isbie_expander

// ### logic/isbie_pkg.sv
// Shared constants and types of the sixteen-bit serial I/O expander.
// Assumes a 125 MHz core clock and a serial link clock of at most fast mode.
package isbie_pkg;

  // Port geometry
  localparam int PORT_W = 8;
  localparam int NUM_PORTS = 2;
  localparam int PIN_W = PORT_W * NUM_PORTS;

  // Bus address: fixed upper nibble, three strap bits, then read/write
  localparam logic [3:0] DEV_ADDR_HI = 4'h4;
  localparam int RW_BIT = 0;
  localparam logic RW_READ = 1'h1;

  // Register pointer: kind in bits 2..1, port in bit 0
  localparam logic [2:0] REG_IN0 = 3'h0;
  localparam logic [2:0] REG_IN1 = 3'h1;
  localparam logic [2:0] REG_OUT0 = 3'h2;
  localparam logic [2:0] REG_OUT1 = 3'h3;
  localparam logic [2:0] REG_POL0 = 3'h4;
  localparam logic [2:0] REG_POL1 = 3'h5;
  localparam logic [2:0] REG_CFG0 = 3'h6;
  localparam logic [2:0] REG_CFG1 = 3'h7;
  localparam logic [1:0] KIND_IN = 2'h0;
  localparam logic [1:0] KIND_OUT = 2'h1;
  localparam logic [1:0] KIND_POL = 2'h2;
  localparam logic [1:0] KIND_CFG = 2'h3;
  localparam int PTR_PORT_BIT = 0;

  // Reset values; a set direction bit means input
  localparam logic [7:0] OUT_RESET = 8'hff;
  localparam logic [7:0] POL_RESET = 8'h00;
  localparam logic [7:0] CFG_RESET = 8'hff;
  localparam logic [2:0] PTR_RESET = 3'h0;

  // Bit counter of the link engine
  localparam logic [3:0] BIT_FIRST = 4'h1;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_ZERO = 4'h0;
  localparam logic [3:0] BIT_STEP = 4'h1;

  // Link speed limit and the core cycles in its shortest half period
  localparam int FAST_MODE_KHZ = 400;
  localparam int CLOCK_MHZ = 125;
  localparam int SCL_MIN_PERIOD_NS = 1000000 / FAST_MODE_KHZ;
  localparam int SCL_MIN_HALF_CYC = (SCL_MIN_PERIOD_NS / 2) * CLOCK_MHZ / 1000;
  localparam int SYNC_STAGES = 2;

  typedef enum logic [2:0] {
    LINK_IDLE,
    LINK_ADDR,
    LINK_CMD,
    LINK_WDATA,
    LINK_RDATA
  } isbie_link_e;

endpackage : isbie_pkg

// ### logic/isbie_sync_if.sv
// Carrier between a synchroniser and its user.
// Assumes the producer of async_d lives outside the consumer's clock domain.
interface isbie_sync_if #(
  parameter int W = 1
);
  logic [W-1:0] async_d;
  logic [W-1:0] sync_q;

  modport sync (input async_d, output sync_q);
  modport user (output async_d, input sync_q);
endinterface : isbie_sync_if

// ### logic/isbie_sync.sv
// Multi-stage level synchroniser, one per bundle of independent bits.
// Assumes each bit is a level that holds for several destination clocks.
module isbie_sync #(
  parameter int W = 1,
  parameter int STAGES = isbie_pkg::SYNC_STAGES
) (
  // Destination clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Bundle to be synchronised
  isbie_sync_if.sync bus
);
  import isbie_pkg::*;

  logic [STAGES-1:0][W-1:0] stage;

  // First stage is read only by the second
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      stage <= '0;
    end else begin
      stage <= {stage[STAGES-2:0], bus.async_d};
    end
  end

  assign bus.sync_q = stage[STAGES-1];

endmodule : isbie_sync

// ### verification/isbie_expander_assertions.sv
// Port-level assertions for the serial I/O expander.
// Assumes a link clock period of more than eight core cycles.
module isbie_expander_assertions import isbie_pkg::*; (
  // Core clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Link and interrupt
  input wire logic link_scl,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic int_out,
  input wire logic int_oe,
  // Pins
  input wire logic [PORT_W-1:0] port0_pin,
  input wire logic [PORT_W-1:0] port0_pin_out,
  input wire logic [PORT_W-1:0] port0_pin_oe,
  input wire logic [PORT_W-1:0] port1_pin,
  input wire logic [PORT_W-1:0] port1_pin_out,
  input wire logic [PORT_W-1:0] port1_pin_oe
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  // Saturating ages: output moves must follow link activity, interrupts a pin or direction move
  logic [4:0] link_age;
  logic [3:0] calm;
  wire logic [31:0] pin_view = {port0_pin, port1_pin, port0_pin_oe, port1_pin_oe};
  wire logic [31:0] drive_view = {port0_pin_out, port1_pin_out, port0_pin_oe, port1_pin_oe};
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      link_age <= 5'h1f;
    end else if ($changed(link_scl)) begin
      link_age <= 5'h00;
    end else if (link_age != 5'h1f) begin
      link_age <= link_age + 5'h01;
    end
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      calm <= 4'h0;
    end else if ($changed(pin_view)) begin
      calm <= 4'h0;
    end else if (calm != 4'hf) begin
      calm <= calm + 4'h1;
    end
  end
  a_reset_inputs: assert property ($rose(rst_b) |-> drive_view == {OUT_RESET, OUT_RESET, 16'h0000} && !int_oe)
    else $error("pins not idle inputs after reset");
  a_int_open_drain: assert property (int_oe |-> !int_out)
    else $error("interrupt drives high");
  a_sda_open_drain: assert property (sda_oe |-> !sda_out)
    else $error("data line driven high");
  a_sda_on_fall: assert property ($changed(sda_oe) |-> !link_scl)
    else $error("data drive moved while link clock high");
  a_sda_rise_hold: assert property ($rose(sda_oe) |-> sda_oe [*8])
    else $error("data pull too short");
  a_sda_fall_hold: assert property ($fell(sda_oe) |-> !sda_oe [*8])
    else $error("data release too short");
  a_pins_latched: assert property ($changed(drive_view) |-> link_age < 5'h10)
    else $error("pin drive moved without a link write");
  a_int_has_cause: assert property ($rose(int_oe) |-> calm < 4'h8 || $changed(pin_view) || link_age < 5'h10)
    else $error("interrupt raised without a pin change");
  a_int_inputs_only: assert property ((drive_view[15:0] == 16'hffff) [*4] |-> !int_oe)
    else $error("interrupt raised with every pin driven");
  c_int_raised: cover property ($rose(int_oe));
  c_int_cleared: cover property ($fell(int_oe));
  c_pin_driven: cover property ($rose(port0_pin_oe[0]));
endmodule : isbie_expander_assertions

bind isbie_expander isbie_expander_assertions i_isbie_expander_assertions (
  .clock, .rst_b, .link_scl, .sda_out, .sda_oe, .int_out, .int_oe,
  .port0_pin, .port0_pin_out, .port0_pin_oe, .port1_pin, .port1_pin_out, .port1_pin_oe
);

// ### verification/isbie_link_master.sv
// Bit-level serial link master standing on the far side of the expander.
// Assumes a pulled-up data line resolved by the bench; clock stands high between frames.
module isbie_link_master (
  // Link lines
  output logic link_scl,
  output logic sda_low,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  // quarter of the 125 ns link period
  localparam realtime QTR = 31.25;
  initial begin
    link_scl = 1'b1;
    sda_low = 1'b0;
  end
  // Data moves only while the clock is low
  task automatic bit_io(input logic b, output logic r);
    sda_low = !b;
    #QTR link_scl = 1'b1;
    #QTR r = sda;
    #QTR link_scl = 1'b0;
    #QTR;
  endtask : bit_io
  task automatic byte_out(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = !r;
  endtask : byte_out
  task automatic frame_start();
    sda_low = 1'b0;
    #QTR link_scl = 1'b1;
    #QTR sda_low = 1'b1;
    #QTR link_scl = 1'b0;
    #QTR;
  endtask : frame_start
  task automatic frame_stop();
    sda_low = 1'b1;
    #QTR link_scl = 1'b1;
    #QTR sda_low = 1'b0;
    #QTR;
  endtask : frame_stop
  task automatic write(input logic [6:0] a, input logic [7:0] cmd, input bit wd, input logic [7:0] d, output logic ack);
    logic k;
    frame_start();
    byte_out({a, 1'b0}, ack);
    if (ack) begin
      byte_out(cmd, k);
      if (wd) byte_out(d, k);
    end
    frame_stop();
  endtask : write
  // Two bytes, acked then refused, so the kept selection is read twice
  task automatic read(input logic [6:0] a, output logic [7:0] d0, output logic [7:0] d1, output logic ack);
    logic r;
    frame_start();
    byte_out({a, 1'b1}, ack);
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d0[i]);
    bit_io(1'b0, r);
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d1[i]);
    bit_io(1'b1, r);
    frame_stop();
  endtask : read
endmodule : isbie_link_master

// ### verification/tb_isbie_expander.sv
// Self-checking bench for the serial I/O expander against an integer register model.
// Assumes the link master model; this bench resolves the pulled-up data line and the pins.
module tb_isbie_expander import isbie_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, rst_b, link_scl, sda_low, sda_out, sda_oe, int_out, int_oe;
  logic [2:0] strap;
  logic [7:0] ext [2];
  logic [PORT_W-1:0] port0_pin, port0_pin_out, port0_pin_oe, port1_pin, port1_pin_out, port1_pin_oe;
  wire logic sda;
  wire logic [6:0] own_addr = {DEV_ADDR_HI, strap};
  int mdl [8];
  int bad_count = 0;
  int checked = 0;
  assign sda = !(sda_low || (sda_oe && !sda_out));
  assign port0_pin = (port0_pin_oe & port0_pin_out) | (~port0_pin_oe & ext[0]);
  assign port1_pin = (port1_pin_oe & port1_pin_out) | (~port1_pin_oe & ext[1]);
  isbie_expander i_isbie_expander (.clock, .rst_b, .link_scl, .sda_in(sda), .sda_out, .sda_oe,
    .addr_select_bit0(strap[0]), .addr_select_bit1(strap[1]), .addr_select_bit2(strap[2]), .port0_pin,
    .port0_pin_out, .port0_pin_oe, .port1_pin, .port1_pin_out, .port1_pin_oe, .int_out, .int_oe);
  isbie_link_master i_isbie_link_master (.link_scl, .sda_low, .sda);
  initial begin
    clock = 1'b0;
    forever #4 clock = !clock;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    checked++;
    if (seen !== want) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test
  task automatic poke(input logic [2:0] s, input logic [7:0] e0, input logic [7:0] e1);
    @(posedge clock);
    strap <= s;
    ext[0] <= e0;
    ext[1] <= e1;
    repeat (3) @(posedge clock);
  endtask : poke
  task automatic wr(input logic [6:0] a, input logic [2:0] c, input bit wd, input logic [7:0] d);
    logic ack;
    i_isbie_link_master.write(a, {5'h00, c}, wd, d, ack);
    check(16'(ack), 16'(a == own_addr));
    // Input registers ignore writes
    if (ack === 1'b1 && wd && c > 3'h1) mdl[c] = d;
  endtask : wr
  task automatic rd(input logic [2:0] c);
    logic [7:0] d0, d1, want;
    logic ack;
    wr(own_addr, c, 1'b0, 8'h00);
    want = 8'(mdl[c]);
    if (c < 3'h2) want = ((8'(mdl[2 + c]) & ~8'(mdl[6 + c])) | (ext[c[0]] & 8'(mdl[6 + c]))) ^ 8'(mdl[4 + c]);
    i_isbie_link_master.read(own_addr, d0, d1, ack);
    check({d1, d0}, {want, want});
  endtask : rd
  task automatic chk_all();
    repeat (6) @(posedge clock);
    check({port1_pin_oe, port0_pin_oe}, ~{8'(mdl[7]), 8'(mdl[6])});
    check({port1_pin_out, port0_pin_out}, {8'(mdl[3]), 8'(mdl[2])});
    for (int c = 0; c < 8; c++) rd(3'(c));
  endtask : chk_all
  task automatic wait_int(input logic want);
    int n;
    for (n = 0; n < 40 && int_oe !== want; n++) @(posedge clock);
    check(16'({int_oe, int_out}), 16'({want, 1'b0}));
    if (n == 40) finish_test();
  endtask : wait_int
  task automatic do_reset();
    @(posedge clock);
    rst_b <= 1'b0;
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    mdl = '{0, 0, 255, 255, 0, 0, 255, 255};
    repeat (8) @(posedge clock);
    check(16'({int_oe, int_out}), 16'h0000);
    chk_all();
    wait_int(1'b0);
  endtask : do_reset
  initial begin
    rst_b = 1'b0;
    strap = 3'h0;
    ext = '{8'h00, 8'h00};
    void'($urandom(75615));
    do_reset();
    // Random data to every command code, inputs included
    repeat (2) begin
      poke(3'($urandom), 8'($urandom), 8'($urandom));
      for (int c = 0; c < 8; c++) wr(own_addr, 3'(c), 1'b1, 8'($urandom));
      chk_all();
    end
    wr(own_addr, REG_CFG0, 1'b1, 8'h00);
    wr(own_addr, REG_CFG1, 1'b1, 8'h00);
    chk_all();
    wr(own_addr, REG_CFG0, 1'b1, 8'hff);
    wr(own_addr, REG_CFG1, 1'b1, 8'hff);
    rd(REG_IN0);
    rd(REG_IN1);
    wait_int(1'b0);
    poke(strap, ext[0] ^ 8'h10, ext[1]);
    wait_int(1'b1);
    rd(REG_IN0);
    wait_int(1'b0);
    poke(strap, ext[0], ext[1] ^ 8'h02);
    wait_int(1'b1);
    poke(strap, ext[0], ext[1] ^ 8'h02);
    wait_int(1'b0);
    // A driven pin never raises the interrupt
    wr(own_addr, REG_CFG0, 1'b1, 8'hfe);
    poke(strap, ext[0] ^ 8'h01, ext[1]);
    repeat (10) @(posedge clock);
    wait_int(1'b0);
    // Every strap setting; a neighbour and a wrong upper nibble are refused
    for (int a = 0; a < 8; a++) begin
      poke(3'(a), ext[0], ext[1]);
      wr({DEV_ADDR_HI, 3'(a ^ 1)}, REG_OUT0, 1'b1, 8'h3c);
      wr(7'h28 | 7'(a), REG_OUT1, 1'b1, 8'h3c);
      rd(REG_OUT0);
    end
    do_reset();
    finish_test();
  end
  initial begin
    repeat (90000) @(posedge clock);
    bad_count++;
    finish_test();
  end
endmodule : tb_isbie_expander
